//--- hrs_halt_reaction.sv
module hrs_halt_reaction (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic clk_en_i,
   input wire hrs_pkg::hrs_optwr_s opt_wr_i,
   input wire logic [15:0] controlword_i,
   input wire logic signed [7:0] active_mode_i,
   input wire hrs_pkg::hrs_evt_s evt_i,
   input wire logic [31:0] follow_window_i,
   input wire logic [31:0] slip_limit_i,
   input wire logic [15:0] mode_decel_i,
   input wire logic [15:0] quick_decel_i,
   input wire logic motor_stopped_i,
   output logic opt_wr_err_o,
   output hrs_pkg::hrs_drv_s drv_o,
   output logic [15:0] decel_o,
   output logic [15:0] err_code_o,
   output logic err_code_vld_o,
   output logic [2:0] active_src_o,
   output logic busy_o
);
   import hrs_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   // every register of the block lives in this one struct
   typedef struct packed {
      logic signed [15:0] opt_shutdown; // stored shutdown option
      logic signed [15:0] opt_disable; // stored disable option
      logic signed [15:0] opt_halt; // stored halt option
      logic signed [15:0] opt_fault; // stored fault option
      logic signed [15:0] opt_follow; // stored following option
      logic wr_err; // last write refused
      hrs_act_e act; // running reaction
      hrs_src_e src; // its cause
      hrs_drv_s drv; // driver commands
      logic [15:0] decel; // chosen deceleration
      logic [15:0] err_code; // error history entry
      logic err_vld; // entry valid
   } hrs_state_s;

   // registered state and the value it takes at the next enabled edge
   hrs_state_s st;
   hrs_state_s next_st;
   logic halt_ok; // halt bit honoured in this mode
   logic mon_on; // following monitoring active
   logic signed [15:0] opt_pick; // option of the event taken
   hrs_src_e src_pick; // event taken this cycle

   // ************************************************************
   // combinational next state
   // ************************************************************
   // one pass: option writes, error record, event pick, driver commands
   always_comb begin
      next_st = st;
      // halt bit only counts in the listed operating modes
      halt_ok = (active_mode_i == MODE_PROF_POS) || (active_mode_i == MODE_VELOCITY)
         || (active_mode_i == MODE_PROF_VEL) || (active_mode_i == MODE_PROF_TRQ)
         || (active_mode_i == MODE_INTERP);
      // either limit at its off value stops following monitoring
      mon_on = (follow_window_i != FOLLOW_WIN_OFF) && (slip_limit_i != SLIP_LIM_OFF);
      // nothing picked unless an event below claims the cycle
      opt_pick = OPT_NO_REACTION;
      src_pick = HRS_SRC_NONE;
      // option writes, reserved values refused
      if (opt_wr_i.wr) begin
         next_st.wr_err = 1'b1;
         unique case (opt_wr_i.sel)
            // shutdown option takes coast or slow ramp only
            3'h0: if (opt_wr_i.value == OPT_RELEASE || opt_wr_i.value == OPT_SLOW_RAMP) begin
               next_st.opt_shutdown = opt_wr_i.value;
               next_st.wr_err = 1'b0;
            end
            // disable option takes coast or slow ramp only
            3'h1: if (opt_wr_i.value == OPT_RELEASE || opt_wr_i.value == OPT_SLOW_RAMP) begin
               next_st.opt_disable = opt_wr_i.value;
               next_st.wr_err = 1'b0;
            end
            // halt option has no coast choice
            3'h2: if (opt_wr_i.value == OPT_SLOW_RAMP || opt_wr_i.value == OPT_QUICK_RAMP) begin
               next_st.opt_halt = opt_wr_i.value;
               next_st.wr_err = 1'b0;
            end
            // fault option: coast, slow or quick
            3'h3: if (opt_wr_i.value >= OPT_RELEASE && opt_wr_i.value <= OPT_QUICK_RAMP) begin
               next_st.opt_fault = opt_wr_i.value;
               next_st.wr_err = 1'b0;
            end
            // following option also allows no reaction
            3'h4: if (opt_wr_i.value >= OPT_NO_REACTION && opt_wr_i.value <= OPT_QUICK_RAMP) begin
               next_st.opt_follow = opt_wr_i.value;
               next_st.wr_err = 1'b0;
            end
            default: next_st.wr_err = 1'b1; // unmapped selector refused
         endcase
      end
      // error history record
      next_st.err_vld = 1'b0;
      if (evt_i.fault) begin
         next_st.err_code = evt_i.fault_code;
         next_st.err_vld = 1'b1;
      end
      // event priority: fault, following, halt, disable, shutdown
      if (evt_i.fault) begin
         src_pick = HRS_SRC_FAULT;
         opt_pick = st.opt_fault;
      end else if (evt_i.follow_err && mon_on && st.opt_follow != OPT_NO_REACTION) begin
         src_pick = HRS_SRC_FOLLOW;
         opt_pick = st.opt_follow;
      end else if (controlword_i[CW_HALT_BIT] && halt_ok && st.act == HRS_ACT_NONE) begin
         src_pick = HRS_SRC_HALT;
         opt_pick = st.opt_halt;
      end else if (evt_i.disable_op) begin
         src_pick = HRS_SRC_DISABLE;
         opt_pick = st.opt_disable;
      end else if (evt_i.shutdown) begin
         src_pick = HRS_SRC_SHUTDOWN;
         opt_pick = st.opt_shutdown;
      end
      // state change requests are one-cycle pulses
      next_st.drv.to_ready = 1'b0;
      next_st.drv.to_switched_on = 1'b0;
      // any new event but halt overrides whatever reaction is running
      if (src_pick != HRS_SRC_NONE) begin
         next_st.src = src_pick;
         unique case (opt_pick)
            // coast: driver off at once, state change right away
            OPT_RELEASE: begin
               next_st.act = HRS_ACT_RELEASE;
               next_st.drv.driver_en = 1'b0;
               next_st.drv.ramp_slow = 1'b0;
               next_st.drv.ramp_quick = 1'b0;
               next_st.drv.to_ready = (src_pick == HRS_SRC_SHUTDOWN);
               next_st.drv.to_switched_on = (src_pick == HRS_SRC_DISABLE);
            end
            // slow-down ramp, state change waits for standstill
            OPT_SLOW_RAMP: begin
               next_st.act = HRS_ACT_SLOW;
               next_st.drv.driver_en = 1'b1;
               next_st.drv.ramp_slow = 1'b1;
               next_st.drv.ramp_quick = 1'b0;
               next_st.decel = mode_decel_i;
            end
            // quick-stop ramp, driver stays energised while braking
            OPT_QUICK_RAMP: begin
               next_st.act = HRS_ACT_QUICK;
               next_st.drv.driver_en = 1'b1;
               next_st.drv.ramp_slow = 1'b0;
               next_st.drv.ramp_quick = 1'b1;
               next_st.decel = quick_decel_i;
            end
            default: next_st.act = st.act; // no reaction
         endcase
      end else if ((st.act == HRS_ACT_SLOW || st.act == HRS_ACT_QUICK) && motor_stopped_i) begin
         // braking finished, state change only now
         next_st.drv.to_ready = (st.src == HRS_SRC_SHUTDOWN);
         next_st.drv.to_switched_on = (st.src == HRS_SRC_DISABLE);
         next_st.drv.ramp_slow = 1'b0;
         next_st.drv.ramp_quick = 1'b0;
         next_st.act = HRS_ACT_NONE;
         next_st.src = HRS_SRC_NONE;
      end else if (st.act == HRS_ACT_SLOW) begin
         // slow ramp follows the mode deceleration as it changes
         next_st.decel = mode_decel_i;
      end else if (st.act == HRS_ACT_QUICK) begin
         // quick ramp follows the quick-stop deceleration likewise
         next_st.decel = quick_decel_i;
      end else if (st.act == HRS_ACT_RELEASE && !evt_i.shutdown && !evt_i.disable_op) begin
         // coasting done, hand back to state machine
         next_st.act = HRS_ACT_NONE;
         next_st.src = HRS_SRC_NONE;
         next_st.drv.driver_en = 1'b1;
      end
   end

   // ************************************************************
   // state register
   // ************************************************************
   // async reset to the default options, driver enabled and idle
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st.opt_shutdown <= SHUTDOWN_OPT_RST;
         st.opt_disable <= DISABLE_OPT_RST;
         st.opt_halt <= HALT_OPT_RST;
         st.opt_fault <= FAULT_OPT_RST;
         st.opt_follow <= FOLLOW_OPT_RST;
         st.wr_err <= 1'b0;
         st.act <= HRS_ACT_NONE;
         st.src <= HRS_SRC_NONE;
         st.drv <= '{driver_en: 1'b1, default: 1'b0};
         st.decel <= 16'h0000;
         st.err_code <= 16'h0000;
         st.err_vld <= 1'b0;
      end else if (clk_en_i) begin
         // enable low holds every bit of state
         st <= next_st;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   // outputs come straight from the state register
   assign opt_wr_err_o = st.wr_err;
   assign drv_o = st.drv;
   assign decel_o = st.decel;
   assign err_code_o = st.err_code;
   assign err_code_vld_o = st.err_vld;
   assign active_src_o = st.src;
   assign busy_o = (st.act != HRS_ACT_NONE);
endmodule

//--- hrs_halt_reaction_asserts.sv
module hrs_halt_reaction_asserts (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic clk_en_i,
   input wire hrs_pkg::hrs_optwr_s opt_wr_i,
   input wire logic [15:0] controlword_i,
   input wire logic signed [7:0] active_mode_i,
   input wire hrs_pkg::hrs_evt_s evt_i,
   input wire logic [31:0] follow_window_i,
   input wire logic [31:0] slip_limit_i,
   input wire logic [15:0] mode_decel_i,
   input wire logic [15:0] quick_decel_i,
   input wire logic motor_stopped_i,
   input wire logic opt_wr_err_o,
   input wire hrs_pkg::hrs_drv_s drv_o,
   input wire logic [15:0] decel_o,
   input wire logic [15:0] err_code_o,
   input wire logic [2:0] active_src_o,
   input wire logic busy_o
);
   timeunit 1ns;
   timeprecision 100ps;
   import hrs_pkg::*;
   // ************************************************************
   // one clock domain, checks off while reset is low
   // ************************************************************
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   logic quiet; // no event this cycle
   logic halt_ok; // halt bit raised with no event while idle, any mode
   assign quiet = clk_en_i && !evt_i.shutdown && !evt_i.disable_op && !evt_i.fault
      && !evt_i.follow_err;
   assign halt_ok = quiet && !busy_o && controlword_i[CW_HALT_BIT];
   sequence ramp_over;
      !drv_o.ramp_slow && !busy_o;
   endsequence
   sequence halt_taken;
      active_src_o == 3'h3 && (drv_o.ramp_slow || drv_o.ramp_quick);
   endsequence
   fault_code_a: assert property (clk_en_i && evt_i.fault |=> active_src_o == 3'h4
      && err_code_o == $past(evt_i.fault_code)) else $error("fault not recorded");
   coast_release_a: assert property (!drv_o.driver_en |-> !drv_o.ramp_slow && !drv_o.ramp_quick)
      else $error("ramp while released");
   slow_decel_a: assert property (drv_o.ramp_slow && $past(clk_en_i)
      |-> decel_o == $past(mode_decel_i)) else $error("slow decel wrong");
   quick_decel_a: assert property (drv_o.ramp_quick && $past(clk_en_i)
      |-> decel_o == $past(quick_decel_i)) else $error("quick decel wrong");
   ready_gate_a: assert property (drv_o.to_ready && $past(drv_o.ramp_slow)
      |-> $past(motor_stopped_i)) else $error("ready before stop");
   ramp_end_a: assert property (drv_o.ramp_slow && motor_stopped_i && quiet |=> ramp_over)
      else $error("ramp not ended");
   halt_take_a: assert property (halt_ok && active_mode_i inside {1, 2, 3, 4, 7}
      |=> halt_taken) else $error("halt not taken");
   halt_mode_a: assert property (halt_ok && !(active_mode_i inside {1, 2, 3, 4, 7})
      |=> active_src_o != 3'h3) else $error("halt in wrong mode");
   follow_off_a: assert property (clk_en_i && evt_i.follow_err && active_src_o != 3'h5
      && (follow_window_i == FOLLOW_WIN_OFF || slip_limit_i == SLIP_LIM_OFF)
      |=> active_src_o != 3'h5) else $error("monitor not off");
   wr_refuse_a: assert property (clk_en_i && opt_wr_i.wr && (opt_wr_i.sel > 3'h4
      || (opt_wr_i.sel == 3'h2 && $signed(opt_wr_i.value) < 16'sh0001)) |=> opt_wr_err_o)
      else $error("reserved write taken");
endmodule
bind hrs_halt_reaction hrs_halt_reaction_asserts i_hrs_halt_reaction_asserts (.core_clk_i,
   .rstn_i, .clk_en_i, .opt_wr_i, .controlword_i, .active_mode_i, .evt_i, .follow_window_i,
   .slip_limit_i, .mode_decel_i, .quick_decel_i, .motor_stopped_i, .opt_wr_err_o, .drv_o,
   .decel_o, .err_code_o, .active_src_o, .busy_o);

//--- hrs_halt_reaction_test.sv
module hrs_halt_reaction_test;
   timeunit 1ns;
   timeprecision 100ps;
   import hrs_pkg::*;
   localparam logic [15:0] MD = 16'h0123, QD = 16'h0456;
   logic clk = 1'b0, rstn = 1'b0, stopped, err, vld, busy;
   hrs_optwr_s wr = '0;
   hrs_evt_s evt = '0;
   hrs_drv_s drv;
   logic [15:0] cw = '0, dec, code;
   logic signed [7:0] mode = MODE_PROF_POS;
   logic [31:0] win = 32'h00000100, slip = 32'h00001000;
   logic [7:0] stop_dly = 8'h05;
   logic [2:0] src;
   logic en = 1'b1; // clock enable of the block
   int bad_count = 0, checks = 0, cyc = 0;
   hrs_halt_reaction i_hrs_halt_reaction (.core_clk_i(clk), .rstn_i(rstn), .clk_en_i(en),
      .opt_wr_i(wr), .controlword_i(cw), .active_mode_i(mode), .evt_i(evt),
      .follow_window_i(win), .slip_limit_i(slip), .mode_decel_i(MD), .quick_decel_i(QD),
      .motor_stopped_i(stopped), .opt_wr_err_o(err), .drv_o(drv), .decel_o(dec),
      .err_code_o(code), .err_code_vld_o(vld), .active_src_o(src), .busy_o(busy));
   hrs_motor_model i_hrs_motor_model (.core_clk_i(clk), .rstn_i(rstn), .drv_i(drv),
      .stop_cycles_i(stop_dly), .motor_stopped_o(stopped));
   initial forever #2 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         tally_and_finish;
      end
   end
   task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task do_reset;
      @(negedge clk);
      rstn = 1'b0;
      repeat (4) @(negedge clk);
      rstn = 1'b1;
   endtask
   task put(input logic [2:0] s, input logic signed [15:0] v);
      @(negedge clk);
      wr = '{1'b1, s, v};
      @(negedge clk);
      wr = '0;
   endtask
   task fire(input logic [2:0] s);
      case (s)
         3'h1: evt.shutdown = 1'b1;
         3'h2: evt.disable_op = 1'b1;
         3'h3: cw[CW_HALT_BIT] = 1'b1;
         3'h4: evt = '{1'b0, 1'b0, 1'b1, 16'hA5C3, 1'b0};
         default: evt.follow_err = 1'b1;
      endcase
      @(negedge clk);
      evt = '0;
      cw = '0;
   endtask
   // one source with one option, then wait out the braking
   task react(input logic [2:0] s, input logic signed [15:0] o);
      int n;
      do_reset;
      put(s - 3'h1, o);
      chk("wr_err", err, 0);
      fire(s);
      chk("src", src, (o == -1) ? 0 : s);
      chk("drv_en", drv.driver_en, o != 0);
      chk("slow", drv.ramp_slow, o == 1);
      chk("quick", drv.ramp_quick, o == 2);
      chk("to_ready", drv.to_ready, s == 1 && o == 0);
      chk("to_sw_on", drv.to_switched_on, s == 2 && o == 0);
      if (o > 0) chk("decel", dec, (o == 1) ? MD : QD);
      if (s == 4) chk("code", {vld, code}, {1'b1, 16'hA5C3});
      if (o == 0) begin
         @(negedge clk);
         chk("rel_end", {drv.driver_en, busy}, 2'b10);
      end
      if (o > 0) begin
         for (n = 0; n < 60 && busy === 1'b1; n++) @(negedge clk);
         chk("end_ready", drv.to_ready, s == 1);
         chk("end_sw_on", drv.to_switched_on, s == 2);
         chk("end_ramp", {drv.ramp_slow, drv.ramp_quick}, 0);
         chk("stop_wait", n >= stop_dly, 1);
      end
      $display("react %0d option %0d done", s, o);
   endtask
   // an event that must be ignored
   task ignored(input logic signed [7:0] m, input logic [31:0] w, input logic [31:0] l,
      input logic [2:0] s);
      do_reset;
      mode = m;
      win = w;
      slip = l;
      fire(s);
      chk("ignored", {src, drv.ramp_slow, drv.ramp_quick}, 0);
      mode = MODE_PROF_POS;
      win = 32'h00000100;
      slip = 32'h00001000;
      $display("ignored source %0d done", s);
   endtask
   // reserved option values refused, stored halt option kept
   task refuse;
      logic [2:0] rs[6] = '{3'h2, 3'h0, 3'h1, 3'h3, 3'h4, 3'h5};
      logic signed [15:0] rv[6] = '{0, 2, -1, 3, -2, 1};
      do_reset;
      foreach (rs[i]) begin
         put(rs[i], rv[i]);
         chk("refused", err, 1);
      end
      fire(3'h3);
      chk("halt_kept", {src, drv.ramp_slow}, {3'h3, 1'b1});
      $display("refuse done");
   endtask
   // values right after reset release
   task rst_vals;
      do_reset;
      chk("rst_drv", drv, 5'h10);
      chk("rst_misc", {src, busy, err, vld}, 0);
      $display("reset values done");
   endtask
   // enable low: a shutdown request must leave no trace
   task freeze;
      do_reset;
      @(negedge clk);
      en = 1'b0;
      fire(3'h1);
      chk("frozen", {src, busy, drv.to_ready}, 0);
      en = 1'b1;
      @(negedge clk);
      chk("thawed", {src, busy}, 0);
      $display("freeze done");
   endtask
   initial begin
      logic signed [7:0] modes[5] = '{1, 2, 3, 4, 7};
      rst_vals;
      for (int s = 1; s <= 2; s++) for (int o = 0; o <= 1; o++) react(s, o);
      foreach (modes[i]) begin
         mode = modes[i];
         react(3'h3, 16'sh0001);
      end
      react(3'h3, 16'sh0002);
      for (int o = 0; o <= 2; o++) react(3'h4, o);
      for (int o = -1; o <= 2; o++) react(3'h5, o);
      stop_dly = 8'h00;
      react(3'h1, 16'sh0001);
      ignored(8'sh05, win, slip, 3'h3);
      ignored(MODE_PROF_POS, FOLLOW_WIN_OFF, slip, 3'h5);
      ignored(MODE_PROF_POS, win, SLIP_LIM_OFF, 3'h5);
      freeze;
      refuse;
      tally_and_finish;
   end
endmodule

//--- hrs_motor_model.sv
// motor reports standstill a set number of cycles into a ramp
module hrs_motor_model (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire hrs_pkg::hrs_drv_s drv_i,
   input wire logic [7:0] stop_cycles_i,
   output logic motor_stopped_o
);
   timeunit 1ns;
   timeprecision 100ps;
   import hrs_pkg::*;
   logic [7:0] run_cnt; // cycles spent braking
   // count braking cycles, clear once both ramps drop
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) run_cnt <= 8'h00;
      else if (drv_i.ramp_slow || drv_i.ramp_quick) run_cnt <= run_cnt + 8'h01;
      else run_cnt <= 8'h00;
   end
   assign motor_stopped_o = (drv_i.ramp_slow || drv_i.ramp_quick) && run_cnt >= stop_cycles_i;
endmodule

//--- hrs_pkg.sv
package hrs_pkg;
   // ************************************************************
   // option values
   // ************************************************************
   localparam logic signed [15:0] OPT_NO_REACTION = 16'shFFFF; // -1, no reaction
   localparam logic signed [15:0] OPT_RELEASE = 16'sh0000; // driver off, coast
   localparam logic signed [15:0] OPT_SLOW_RAMP = 16'sh0001; // mode slow-down ramp
   localparam logic signed [15:0] OPT_QUICK_RAMP = 16'sh0002; // quick-stop ramp
   // ************************************************************
   // reset values of stored options
   // ************************************************************
   localparam logic signed [15:0] SHUTDOWN_OPT_RST = 16'sh0001; // shutdown option
   localparam logic signed [15:0] DISABLE_OPT_RST = 16'sh0001; // disable-op option
   localparam logic signed [15:0] HALT_OPT_RST = 16'sh0001; // halt option
   localparam logic signed [15:0] FAULT_OPT_RST = 16'sh0002; // fault option
   localparam logic signed [15:0] FOLLOW_OPT_RST = 16'sh0001; // following option
   // ************************************************************
   // controlword and monitoring limits
   // ************************************************************
   localparam int CW_HALT_BIT = 8; // halt bit position
   localparam logic [31:0] FOLLOW_WIN_OFF = 32'hFFFFFFFF; // -1 disables
   localparam logic [31:0] SLIP_LIM_OFF = 32'h7FFFFFFF; // max positive disables
   // ************************************************************
   // operating modes that honour halt
   // ************************************************************
   localparam logic signed [7:0] MODE_PROF_POS = 8'sh01; // profile position
   localparam logic signed [7:0] MODE_VELOCITY = 8'sh02; // velocity
   localparam logic signed [7:0] MODE_PROF_VEL = 8'sh03; // profile velocity
   localparam logic signed [7:0] MODE_PROF_TRQ = 8'sh04; // profile torque
   localparam logic signed [7:0] MODE_INTERP = 8'sh07; // interpolated position
   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {
      HRS_ACT_NONE,
      HRS_ACT_RELEASE,
      HRS_ACT_SLOW,
      HRS_ACT_QUICK
   } hrs_act_e;
   typedef enum logic [2:0] {
      HRS_SRC_NONE,
      HRS_SRC_SHUTDOWN,
      HRS_SRC_DISABLE,
      HRS_SRC_HALT,
      HRS_SRC_FAULT,
      HRS_SRC_FOLLOW
   } hrs_src_e;
   typedef enum logic [1:0] {
      HRS_OPT_SHUTDOWN,
      HRS_OPT_DISABLE,
      HRS_OPT_HALT,
      HRS_OPT_FAULT
   } hrs_optsel_e;
   // option write port
   typedef struct packed {
      logic wr;
      logic [2:0] sel; // 0..3 per hrs_optsel_e, 4 = following option
      logic signed [15:0] value;
   } hrs_optwr_s;
   // reaction request events
   typedef struct packed {
      logic shutdown;
      logic disable_op;
      logic fault;
      logic [15:0] fault_code;
      logic follow_err;
   } hrs_evt_s;
   // drive command outputs
   typedef struct packed {
      logic driver_en;
      logic ramp_slow;
      logic ramp_quick;
      logic to_ready;
      logic to_switched_on;
   } hrs_drv_s;
endpackage
